// ===== sar_pkg.sv
// Shared constants and types for the converter sequencing and serial readout.
// Assumes a single system clock; all pins are sampled by that clock.
package sar_pkg;
   localparam int RES_W = 16;
   localparam int IDX_W = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int CNT_W = 3;
   // Falling edges spent sampling before the null bit
   localparam logic [CNT_W-1:0] SMPL_FALLS = 3'h5;
   localparam logic [IDX_W-1:0] IDX_MSB = 4'hf;
   localparam logic [IDX_W-1:0] IDX_LSB = 4'h0;
   localparam logic [IDX_W-1:0] IDX_REPLAY_FIRST = 4'h1;
   // Offset-binary midpoint trial, also the sign flip for two's complement
   localparam logic [RES_W-1:0] TRIAL_MID = 16'h8000;
   localparam logic [RES_W-1:0] CODE_ZERO = 16'h0000;

   typedef enum logic [2:0] {
      SAR_IDLE = 3'b000,
      SAR_ACQ = 3'b001,
      SAR_CONV = 3'b010,
      SAR_REPLAY = 3'b011,
      SAR_DONE = 3'b100
   } sar_state_e;

   // One decided bit on its way to the serial output
   typedef struct packed {
      logic last;
      logic val;
   } sar_bit_s;
endpackage

// ===== sar_sync.sv
// Two flip-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is an unrelated asynchronous level.
`timescale 1ns/100ps
`default_nettype none
module sar_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== sar_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/100ps
`default_nettype none
module sar_fifo #(
   parameter int W = 2,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;

   // Handshake decode
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != FULL_CNT);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];

   // Storage array
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule
`default_nettype wire

// ===== sar_readout.sv
// Conversion sequencer and serial readout of a 16-bit sampling converter.
// Assumes serial_clock, conv_sel_n and comp_hi are asynchronous pins; the
// successive approximation bits run through a FIFO to the serial output.
`timescale 1ns/100ps
`default_nettype none
module sar_readout #(
   parameter int RES_W = sar_pkg::RES_W,
   parameter int FIFO_DEPTH = sar_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic serial_clock,
   input wire logic conv_sel_n,
   input wire logic comp_hi,
   output logic dout,
   output logic dout_oe,
   output logic sample_en,
   output logic power_down,
   output logic [RES_W-1:0] dac_code
);
   localparam int BIT_W = $bits(sar_pkg::sar_bit_s);

   logic [2:0] pins_s;
   logic sclk_prev_q;
   logic sel_prev_q;
   sar_pkg::sar_state_e state_q;
   logic [sar_pkg::CNT_W-1:0] fall_cnt_q;
   logic [sar_pkg::IDX_W-1:0] dec_idx_q;
   logic dec_done_q;
   logic [sar_pkg::IDX_W-1:0] rep_idx_q;
   logic rep_end_q;
   logic [RES_W-1:0] result_q;
   logic [RES_W-1:0] trial_q;
   logic fifo_in_ready;
   logic fifo_out_valid;
   sar_pkg::sar_bit_s fifo_out;
   sar_pkg::sar_bit_s fifo_in;

   // Pin synchronisers
   sar_sync #(
      .W(3)
   ) u_sync (
      .clk(sys_clk),
      .nrst(nrst),
      .async_in({serial_clock, conv_sel_n, comp_hi}),
      .sync_out(pins_s)
   );

   // Synchronised pins and edge decode
   wire sclk_s = pins_s[2];
   wire sel_n_s = pins_s[1];
   wire comp_s = pins_s[0];
   wire sclk_fall = sclk_prev_q && !sclk_s;
   wire sclk_rise = !sclk_prev_q && sclk_s;
   wire sel_fall = sel_prev_q && !sel_n_s;
   wire start_conv = sel_fall && (state_q == sar_pkg::SAR_IDLE);
   wire acq_end = (state_q == sar_pkg::SAR_ACQ) && sclk_fall
      && (fall_cnt_q == sar_pkg::SMPL_FALLS - 3'h1);

   // Bit decision, MSB flipped into two's complement
   wire [RES_W-1:0] idx_mask = RES_W'(1) << dec_idx_q;
   wire dec_now = (state_q == sar_pkg::SAR_CONV) && sclk_rise && !dec_done_q
      && fifo_in_ready;
   wire dec_bit = comp_s ^ (dec_idx_q == sar_pkg::IDX_MSB);
   wire [RES_W-1:0] trial_kept = comp_s ? trial_q : (trial_q & ~idx_mask);
   wire [RES_W-1:0] trial_next = trial_kept | (idx_mask >> 1);
   assign fifo_in.val = dec_bit;
   assign fifo_in.last = (dec_idx_q == sar_pkg::IDX_LSB);

   // Launch decode for the serial output
   wire pop_now = (state_q == sar_pkg::SAR_CONV) && sclk_fall && fifo_out_valid;
   wire rep_now = (state_q == sar_pkg::SAR_REPLAY) && sclk_fall;
   wire flush = sel_n_s;

   // Decided bits wait here for their falling edge
   sar_fifo #(
      .W(BIT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(sys_clk),
      .nrst(nrst),
      .flush(flush),
      .in_valid(dec_now),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(pop_now),
      .out_data(fifo_out)
   );

   // Edge history
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sclk_prev_q <= 1'b0;
         sel_prev_q <= 1'b0; // Matches the synchroniser reset level, so no false fall
      end else begin
         sclk_prev_q <= sclk_s;
         sel_prev_q <= sel_n_s;
      end
   end

   // Sequencer state
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= sar_pkg::SAR_IDLE;
      end else if (sel_n_s) begin
         state_q <= sar_pkg::SAR_IDLE;
      end else begin
         unique case (state_q)
            sar_pkg::SAR_IDLE: begin
               if (start_conv) begin
                  state_q <= sar_pkg::SAR_ACQ;
               end
            end
            sar_pkg::SAR_ACQ: begin
               if (acq_end) begin
                  state_q <= sar_pkg::SAR_CONV;
               end
            end
            sar_pkg::SAR_CONV: begin
               if (pop_now && fifo_out.last) begin
                  state_q <= sar_pkg::SAR_REPLAY;
               end
            end
            sar_pkg::SAR_REPLAY: begin
               if (rep_now && rep_end_q) begin
                  state_q <= sar_pkg::SAR_DONE;
               end
            end
            sar_pkg::SAR_DONE: begin
               state_q <= sar_pkg::SAR_DONE;
            end
            default: begin
               state_q <= sar_pkg::SAR_IDLE;
            end
         endcase
      end
   end

   // Sampling period counter in falling edges
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fall_cnt_q <= '0;
      end else if (state_q != sar_pkg::SAR_ACQ) begin
         fall_cnt_q <= '0;
      end else if (sclk_fall) begin
         fall_cnt_q <= fall_cnt_q + 3'h1;
      end
   end

   // Successive approximation on rising edges
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         trial_q <= sar_pkg::TRIAL_MID;
         dec_idx_q <= sar_pkg::IDX_MSB;
         dec_done_q <= 1'b0;
         result_q <= sar_pkg::CODE_ZERO;
      end else if (start_conv) begin
         trial_q <= sar_pkg::TRIAL_MID;
         dec_idx_q <= sar_pkg::IDX_MSB;
         dec_done_q <= 1'b0;
      end else if (dec_now) begin
         trial_q <= trial_next;
         result_q[dec_idx_q] <= dec_bit;
         dec_idx_q <= dec_idx_q - 4'h1;
         dec_done_q <= (dec_idx_q == sar_pkg::IDX_LSB);
      end
   end

   // Reversed replay index
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rep_idx_q <= sar_pkg::IDX_REPLAY_FIRST;
         rep_end_q <= 1'b0;
      end else if (state_q != sar_pkg::SAR_REPLAY) begin
         rep_idx_q <= sar_pkg::IDX_REPLAY_FIRST;
         rep_end_q <= 1'b0;
      end else if (rep_now && !rep_end_q) begin
         rep_idx_q <= rep_idx_q + 4'h1;
         rep_end_q <= (rep_idx_q == sar_pkg::IDX_MSB);
      end
   end

   // Serial data and its enable, changed only on falling edges or cleared while select is high
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dout <= 1'b0;
         dout_oe <= 1'b0;
      end else if (sel_n_s) begin
         dout <= 1'b0;
         dout_oe <= 1'b0;
      end else if (acq_end) begin
         dout <= 1'b0;
         dout_oe <= 1'b1;
      end else if (pop_now) begin
         dout <= fifo_out.val;
      end else if (rep_now) begin
         dout <= rep_end_q ? 1'b0 : result_q[rep_idx_q];
         dout_oe <= !rep_end_q;
      end
   end

   // Analog controls: sampling, trial code, power-down
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sample_en <= 1'b0;
         power_down <= 1'b1;
         dac_code <= sar_pkg::TRIAL_MID;
      end else begin
         sample_en <= (state_q == sar_pkg::SAR_ACQ) && !sel_n_s;
         power_down <= sel_n_s || (state_q == sar_pkg::SAR_IDLE)
            || dec_done_q || (state_q == sar_pkg::SAR_DONE);
         dac_code <= trial_q;
      end
   end
endmodule
`default_nettype wire

// ===== sar_host_model.sv
// Host serial master and analog input model for the converter readout.
// Assumes sys_clk runs; serial_clock and conv_sel_n change only at its falling edge, comp_hi follows dac_code.
`timescale 1ns/100ps
`default_nettype none
module sar_host_model (
   input wire logic sys_clk,
   input wire logic [15:0] vin_code,
   input wire logic [15:0] dac_code,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic sample_en,
   input wire logic power_down,
   output logic serial_clock,
   output logic conv_sel_n,
   output logic comp_hi
);
   logic d_s [0:47];
   logic oe_s [0:47];
   logic se_s [0:47];
   logic pd_s [0:47];
   logic d_last;
   logic line;
   // Ideal comparator against the trial code
   assign comp_hi = (vin_code >= dac_code);
   // Released data line shows the inverse of its last level
   assign line = dout_oe ? dout : ~d_last;
   initial begin
      serial_clock = 1'b0;
      conv_sel_n = 1'b1;
      d_last = 1'b0;
   end
   // Half of a 200 ns serial clock period, a fixed fast rate
   task half;
      repeat (4) @(negedge sys_clk);
   endtask
   // One frame of n falling serial clock edges with select low
   task frame(input int n);
      int k;
      begin
         conv_sel_n = 1'b0;
         half();
         serial_clock = 1'b1;
         for (k = 1; k <= n; k++) begin
            half();
            serial_clock = 1'b0;
            half();
            d_s[k] = line;
            if (dout_oe) begin
               d_last = dout;
            end
            oe_s[k] = dout_oe;
            se_s[k] = sample_en;
            pd_s[k] = power_down;
            serial_clock = 1'b1;
         end
         half();
         conv_sel_n = 1'b1;
         half();
         serial_clock = 1'b0;
         // Short frames are padded so every select cycle lasts at least 10 us
         repeat ((n < 37) ? 400 - 8 * n : 100) @(negedge sys_clk);
      end
   endtask
endmodule
`default_nettype wire

// ===== sar_readout_checker.sv
// Concurrent checks on the converter readout pins.
// Assumes sys_clk samples every pin; bound onto sar_readout.
`timescale 1ns/100ps
`default_nettype none
module sar_readout_checker #(
   parameter int RES_W = 16
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic serial_clock,
   input wire logic conv_sel_n,
   input wire logic comp_hi,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic sample_en,
   input wire logic power_down,
   input wire logic [RES_W-1:0] dac_code
);
   logic sc_q;
   logic [3:0] age_q;
   logic [3:0] age_d;
   // Cycles since the serial clock pin last fell, saturating
   assign age_d = (sc_q && !serial_clock) ? 4'h0 : (age_q == 4'hf) ? age_q : age_q + 4'h1;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sc_q <= 1'b0;
         age_q <= 4'hf;
      end else begin
         sc_q <= serial_clock;
         age_q <= age_d;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Select parked high, then taken low
   sequence sel_idle;
      conv_sel_n [*6];
   endsequence
   sequence sel_fall;
      sel_idle ##1 !conv_sel_n;
   endsequence
   chk_start_acq: assert property (sel_fall |-> ##[1:6] sample_en)
      else $error("sampling did not start after select fell");
   chk_sel_release: assert property (sel_idle |-> !dout_oe)
      else $error("data driven while select high");
   chk_sel_power: assert property (sel_idle |-> power_down && !sample_en)
      else $error("not powered down while select high");
   chk_dout_edge: assert property ($changed(dout) && dout_oe && $past(dout_oe) |->
      age_q inside {[2:5]})
      else $error("data changed away from a serial clock fall");
   chk_oe_edge: assert property ($rose(dout_oe) |-> age_q inside {[2:5]} && !dout)
      else $error("null bit not launched by a fall");
   chk_acq_end: assert property ($rose(dout_oe) |-> ##1 $fell(sample_en))
      else $error("sampling did not end with the null bit");
   chk_no_restart: assert property ($fell(dout_oe) && !conv_sel_n |-> (!sample_en) [*8])
      else $error("conversion restarted with select held low");
   chk_done_power: assert property ($fell(dout_oe) && !conv_sel_n |-> power_down)
      else $error("not powered down after completion");
   chk_awake_acq: assert property (sample_en |-> !power_down)
      else $error("sampling while powered down");
   chk_trial_mid: assert property (sample_en |-> dac_code == {1'b1, {(RES_W-1){1'b0}}})
      else $error("trial code not at midpoint while sampling");
endmodule
bind sar_readout sar_readout_checker #(.RES_W(RES_W)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .serial_clock(serial_clock), .conv_sel_n(conv_sel_n),
   .comp_hi(comp_hi), .dout(dout), .dout_oe(dout_oe), .sample_en(sample_en),
   .power_down(power_down), .dac_code(dac_code)
);
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the converter sequencing and serial readout.
// Assumes the host model and the bound checker compile alongside.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic sys_clk, nrst, serial_clock, conv_sel_n, comp_hi, dout, dout_oe;
   logic sample_en, power_down;
   logic [15:0] dac_code, vin;
   int bad_count, n_checks;
   sar_readout u_dut (.sys_clk(sys_clk), .nrst(nrst), .serial_clock(serial_clock),
      .conv_sel_n(conv_sel_n), .comp_hi(comp_hi), .dout(dout), .dout_oe(dout_oe),
      .sample_en(sample_en), .power_down(power_down), .dac_code(dac_code));
   sar_host_model u_host (.sys_clk(sys_clk), .vin_code(vin), .dac_code(dac_code),
      .dout(dout), .dout_oe(dout_oe), .sample_en(sample_en), .power_down(power_down),
      .serial_clock(serial_clock), .conv_sel_n(conv_sel_n), .comp_hi(comp_hi));
   // 40 MHz system clock
   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;
   task chk_bit(input string what, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %b seen %b", what, e, g);
      end
   endtask
   task chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Runs one frame of n falls for input code v and judges every bit slot
   task check_frame(input logic [15:0] v, input int n);
      logic [15:0] e, got;
      int k;
      begin
         e = v - 16'h8000;
         vin = v;
         u_host.frame(n);
         for (k = 1; k <= n; k++) begin
            if (k < 5) chk_bit("enable while sampling", 1'b0, u_host.oe_s[k]);
            else if (k == 5) chk_bit("null bit", 1'b0, u_host.d_s[k] | !u_host.oe_s[k]);
            else if (k <= 21) got[21-k] = u_host.oe_s[k] ? u_host.d_s[k] : 1'bx;
            else if (k <= 36) chk_bit("replay bit", e[k-21], u_host.oe_s[k] ? u_host.d_s[k] : 1'bx);
            else chk_bit("released", 1'b0, u_host.oe_s[k]);
            if (k == 3) chk_bit("sampling", 1'b1, u_host.se_s[k]);
            if (k == 22) chk_bit("done power", 1'b1, u_host.pd_s[k]);
            if (k == 10) chk_bit("awake power", 1'b0, u_host.pd_s[k]);
         end
         if (n >= 21) chk_word("result", e, got);
         if (n > 5 && n < 21) chk_word("leading bits", e >> (21 - n), got >> (21 - n));
      end
   endtask
   task test_codes;
      logic [15:0] tbl [0:4];
      int i;
      begin
         tbl = '{16'hffff, 16'h8000, 16'h7fff, 16'h0000, 16'h5a3c};
         for (i = 0; i < 5; i++) check_frame(tbl[i], 37);
      end
   endtask
   task test_hold_low;
      check_frame(16'h1234, 45);
      chk_bit("no restart", 1'b0, u_host.se_s[45]);
   endtask
   task test_abort;
      check_frame(16'hc3a5, 10);
      chk_bit("abort release", 1'b0, dout_oe);
      chk_bit("abort power", 1'b1, power_down);
      check_frame(16'h4321, 37);
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      wrap_up();
   end
   initial begin
      bad_count = 0;
      n_checks = 0;
      nrst = 1'b0;
      vin = 16'h0000;
      repeat (5) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
      test_codes();
      test_hold_low();
      test_abort();
      wrap_up();
   end
endmodule
`default_nettype wire
